/* File: hsp_host_port.sv */
// Host access port: parallel byte bus or serial link onto registers and buffer.
// Assumes pins synchronous to ref_clk; event inputs are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module hsp_host_port import hsp_pkg::*; #(
    parameter int MEM_BYTES = 32768    // Byte locations behind the port
) (
    input wire logic ref_clk,                 // Core clock
    input wire logic rst_n,                   // Synchronous reset, active low
    input wire logic spi_en,                  // Serial-select strap
    input wire hsp_bus_type bus,              // Parallel pins
    input wire logic [NSOCK*NEVT-1:0] sock_evt, // Socket event pulses
    input wire logic [3:0] com_evt,           // Common event pulses, flags 7:4
    input wire logic [NSOCK*16-1:0] rx_size,  // Received size per socket
    output logic [7:0] data_out,              // Data pins out
    output logic data_oe_n,                   // Low while driving data
    output logic miso_out,                    // Serial out on A[11]
    output logic miso_oe_n,                   // Low while driving A[11]
    output logic int_n                        // Interrupt, active low
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] imr;
        logic [3:0] cflags;
        logic [NSOCK*NEVT-1:0] sflags;
        logic spi_mode;
        logic wr_act;
        logic [14:0] wr_addr;
        logic [7:0] wr_data;
        logic [7:0] dout;
        logic doe_n;
        logic int_n;
        logic [7:0] spi_rdata;
    } hsp_host_state_type;

    hsp_host_state_type s_q, s_d;
    logic [7:0] mem [MEM_BYTES];       // Buffer memory, no reset
    hsp_req_type spi_req;              // Serial requests
    logic spi_miso;                    // Serial out from front end
    logic spi_oe_n;                    // Serial out enable
    logic par_rd;                      // Parallel read in progress
    logic par_wr;                      // Parallel write strobe rising
    logic wr_en;                       // Write into map
    logic [14:0] wr_addr;              // Write address
    logic [7:0] wr_data;               // Write data
    logic [7:0] cir;                   // Common event flags view

    // True for register addresses, held in flip-flops or read from inputs rather than memory
    function automatic logic is_reg(input logic [14:0] a);
        logic sock;
        sock = (a[14:10] == SOCK_REGION);
        return (a == MODE_ADDR) || (a == CIR_ADDR) || (a == IMR_ADDR)
            || (sock && (a[7:0] == SIR_OFF || a[7:0] == RSR_HI_OFF
            || a[7:0] == RSR_LO_OFF));
    endfunction

    // Common flags: socket summaries low, common events high
    function automatic logic [7:0] cflag_view(input hsp_host_state_type s);
        logic [7:0] v;
        v = {s.cflags, 4'h0};
        for (int n = 0; n < NSOCK; n++) begin
            v[n] = |s.sflags[n*NEVT +: NEVT];
        end
        return v;
    endfunction

    // Byte seen at an address by either access path
    function automatic logic [7:0] rd_byte(input logic [14:0] a);
        logic [1:0] n;
        logic [15:0] sz;
        n = a[9:8];
        sz = rx_size[n*16 +: 16];
        rd_byte = mem[a[$clog2(MEM_BYTES)-1:0]];
        if (a == MODE_ADDR) begin
            rd_byte = s_q.mode;
        end else if (a == CIR_ADDR) begin
            rd_byte = cflag_view(s_q);
        end else if (a == IMR_ADDR) begin
            rd_byte = s_q.imr;
        end else if (a[14:10] == SOCK_REGION) begin
            if (a[7:0] == SIR_OFF) begin
                rd_byte = {4'h0, s_q.sflags[n*NEVT +: NEVT]};
            end else if (a[7:0] == RSR_HI_OFF) begin
                rd_byte = sz[15:8];
            end else if (a[7:0] == RSR_LO_OFF) begin
                rd_byte = sz[7:0];
            end
        end
    endfunction

    hsp_spi_slave u_spi (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(s_q.spi_mode),
        .sclk(bus.addr[14]),
        .ss_n(bus.addr[13]),
        .mosi(bus.addr[12]),
        .rdata(s_q.spi_rdata),
        .req(spi_req),
        .miso(spi_miso),
        .miso_oe_n(spi_oe_n)
    );

    // Next-state logic for bus, flags and interrupt
    always_comb begin
        s_d = s_q;
        s_d.spi_mode = spi_en;
        par_rd = !s_q.spi_mode && !bus.cs_n && !bus.rd_n && bus.wr_n;
        s_d.wr_act = !s_q.spi_mode && !bus.cs_n && !bus.wr_n && bus.rd_n;
        if (s_d.wr_act) begin
            s_d.wr_addr = bus.addr;
            s_d.wr_data = bus.data;
        end
        par_wr = s_q.wr_act && bus.wr_n;
        wr_en = par_wr || spi_req.wr;
        wr_addr = par_wr ? s_q.wr_addr : spi_req.addr;
        wr_data = par_wr ? s_q.wr_data : spi_req.data;
        s_d.doe_n = !par_rd;
        if (par_rd) begin
            s_d.dout = rd_byte(bus.addr);
        end
        if (spi_req.rd) begin
            s_d.spi_rdata = rd_byte(spi_req.addr);
        end
        if (wr_en) begin
            if (wr_addr == MODE_ADDR) begin
                s_d.mode = wr_data;
            end else if (wr_addr == IMR_ADDR) begin
                s_d.imr = wr_data;
            end else if (wr_addr == CIR_ADDR) begin
                s_d.cflags = s_q.cflags & ~wr_data[7:4];
                for (int n = 0; n < NSOCK; n++) begin
                    if (wr_data[n]) begin
                        s_d.sflags[n*NEVT +: NEVT] = '0;
                    end
                end
            end else if (wr_addr[14:10] == SOCK_REGION && wr_addr[7:0] == SIR_OFF) begin
                s_d.sflags[wr_addr[9:8]*NEVT +: NEVT] =
                    s_q.sflags[wr_addr[9:8]*NEVT +: NEVT] & ~wr_data[NEVT-1:0];
            end
        end
        // flags recorded even if masked; a new event beats a clear
        s_d.sflags = s_d.sflags | sock_evt;
        s_d.cflags = s_d.cflags | com_evt;
        cir = cflag_view(s_q);
        s_d.int_n = ~|(cir & s_q.imr);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.mode <= MODE_RST;
            s_q.imr <= IMR_RST;
            s_q.doe_n <= 1'b1;
            s_q.int_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Buffer memory writes; register addresses stay out of it
    always_ff @(posedge ref_clk) begin
        if (wr_en && !is_reg(wr_addr)) begin
            mem[wr_addr[$clog2(MEM_BYTES)-1:0]] <= wr_data;
        end
    end

    assign data_out = s_q.dout;
    assign data_oe_n = s_q.doe_n;
    assign int_n = s_q.int_n;
    assign miso_out = spi_miso;
    assign miso_oe_n = spi_oe_n;

    property p_reset_defaults;
        @(posedge ref_clk) !rst_n |=> s_q.imr == IMR_RST && s_q.mode == MODE_RST && int_n;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset left state");

    property p_par_off_in_spi;
        @(posedge ref_clk) disable iff (!rst_n) s_q.spi_mode |=> data_oe_n;
    endproperty
    a_par_off_in_spi: assert property (p_par_off_in_spi) else $error("parallel read in serial mode");

    property p_read_drives;
        @(posedge ref_clk) disable iff (!rst_n)
            par_rd && !wr_en && !(|sock_evt) && !(|com_evt) |=> !data_oe_n
            && data_out == $past(rd_byte(bus.addr));
    endproperty
    a_read_drives: assert property (p_read_drives) else $error("read byte not driven");

    property p_release;
        @(posedge ref_clk) disable iff (!rst_n) (bus.cs_n || bus.rd_n) |=> data_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("data pins driven while idle");

    property p_imr_write;
        @(posedge ref_clk) disable iff (!rst_n)
            s_q.wr_act && !bus.wr_n ##1 bus.wr_n && s_q.wr_addr == IMR_ADDR
            |=> s_q.imr == $past(s_q.wr_data);
    endproperty
    a_imr_write: assert property (p_imr_write) else $error("write not taken at rise");

    property p_int_assert;
        @(posedge ref_clk) disable iff (!rst_n) |(cflag_view(s_q) & s_q.imr) |=> !int_n;
    endproperty
    a_int_assert: assert property (p_int_assert) else $error("unmasked flag without interrupt");

    property p_int_mask;
        @(posedge ref_clk) disable iff (!rst_n) (s_q.imr == 8'h00) [*2] |-> int_n;
    endproperty
    a_int_mask: assert property (p_int_mask) else $error("masked flag raised interrupt");

    property p_int_clear;
        @(posedge ref_clk) disable iff (!rst_n) !(|(cflag_view(s_q) & s_q.imr)) |=> int_n;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt held after clear");

    property p_set_wins;
        @(posedge ref_clk) disable iff (!rst_n) sock_evt[0] |=> s_q.sflags[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

    property p_big_endian;
        @(posedge ref_clk) disable iff (!rst_n)
            par_rd && bus.addr == {SOCK_REGION, 2'h0, RSR_HI_OFF} && $stable(rx_size)
            |=> data_out == rx_size[15:8];
    endproperty
    a_big_endian: assert property (p_big_endian) else $error("byte order wrong");

    c_par_read: cover property (@(posedge ref_clk) disable iff (!rst_n) par_rd ##1 !par_rd);
    c_par_write: cover property (@(posedge ref_clk) disable iff (!rst_n) par_wr);
    c_int_fire: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(int_n));
    c_byte_order_set: cover property (@(posedge ref_clk) disable iff (!rst_n)
        s_q.mode[BYTE_ORDER_BIT]);
endmodule
`default_nettype wire

/* File: hsp_pkg.sv */
// Constants and carrier types shared by the host access port.
// Assumes one 50 MHz clock and pins that are synchronous to it.
// What this block does
// - Reset low at least 2us restores defaults
// - Strap high turns upper address pins serial
// - Slave select low frames serial, high ignores
// - Strap low or open selects parallel bus
// - Serial link uses clock mode zero only
// - Fifteen-bit address selects one byte location
// - Chip select with one strobe starts access
// - Write data captured at strobe rising edge
// - Read strobe drives addressed byte onto data
// - Unmasked socket event pulls interrupt low
// - Writing flag registers clears pending interrupt
// - Each socket and each common event has one mask bit; a socket's four events share it
// - Multi-byte values are big-endian only
// - Byte order bit has no effect
`default_nettype none
package hsp_pkg;
    localparam int ADDR_W = 15;                   // Address pins
    localparam int DATA_W = 8;                    // Data pins
    localparam int NSOCK = 4;                     // Sockets
    localparam int NEVT = 4;                      // Events per socket
    // Register map
    localparam logic [14:0] MODE_ADDR = 15'h0000; // Global mode register
    localparam logic [14:0] CIR_ADDR = 15'h0015;  // Common event flags
    localparam logic [14:0] IMR_ADDR = 15'h0016;  // Interrupt mask
    localparam logic [4:0] SOCK_REGION = 5'h01;   // Addr[14:10] of socket space
    localparam logic [7:0] SIR_OFF = 8'h02;       // Socket event flags offset
    localparam logic [7:0] RSR_HI_OFF = 8'h26;    // Received size, high byte
    localparam logic [7:0] RSR_LO_OFF = 8'h27;    // Received size, low byte
    localparam int BYTE_ORDER_BIT = 0;            // Byte order bit in mode reg
    localparam logic [7:0] MODE_RST = 8'h00;      // Mode reset value
    localparam logic [7:0] IMR_RST = 8'h00;       // Mask reset value
    // Timing
    localparam int CLK_NS = 20;                   // Clock period
    localparam int RST_MIN_NS = 2000;             // Least reset pulse
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    // Serial framing: opcode, 16-bit address, one data byte
    localparam logic [7:0] SPI_OP_WR = 8'hf0;     // Write opcode
    localparam logic [7:0] SPI_OP_RD = 8'h0f;     // Read opcode
    localparam logic [5:0] SPI_HDR_LAST = 6'h17;  // Count at last header bit
    localparam logic [5:0] SPI_FRM_LAST = 6'h1f;  // Count at last frame bit

    // Parallel bus pins as sampled
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic [14:0] addr;
        logic [7:0] data;
    } hsp_bus_type;

    // Access request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [14:0] addr;
        logic [7:0] data;
    } hsp_req_type;
endpackage
`default_nettype wire

/* File: hsp_spi_slave.sv */
// Serial front end: mode-zero slave turning frames into byte requests.
// Assumes serial clock far slower than ref_clk (half period >= 4 cycles).
`timescale 1ns/10ps
`default_nettype none
module hsp_spi_slave import hsp_pkg::*; (
    input wire logic ref_clk,          // Core clock
    input wire logic rst_n,            // Synchronous reset
    input wire logic enable,           // Serial mode selected
    input wire logic sclk,             // Serial clock
    input wire logic ss_n,             // Slave select
    input wire logic mosi,             // Serial data in
    input wire logic [7:0] rdata,      // Read byte from main
    output hsp_req_type req,           // Request pulses
    output logic miso,                 // Serial data out
    output logic miso_oe_n             // Low while driving serial out
);
    typedef struct packed {
        logic sclk;
        logic [5:0] cnt;
        logic [23:0] sin;
        logic [7:0] op;
        logic [14:0] addr;
        logic [7:0] sout;
        hsp_req_type req;
        logic miso;
        logic oe_n;
    } hsp_spi_state_type;

    hsp_spi_state_type s_q, s_d;
    logic active;                      // Frame in progress
    logic rise;                        // Sampling edge
    logic fall;                        // Shifting edge
    logic [23:0] sin_n;                // Shift-in after this bit

    // Edge detection and frame decode
    always_comb begin
        s_d = s_q;
        active = enable & ~ss_n;
        rise = active & sclk & ~s_q.sclk;
        fall = active & ~sclk & s_q.sclk;
        sin_n = {s_q.sin[22:0], mosi};
        s_d.sclk = sclk;
        s_d.req.wr = 1'b0;
        s_d.req.rd = 1'b0;
        if (!active) begin
            s_d.cnt = '0;
            s_d.oe_n = 1'b1;
            s_d.miso = 1'b0;
        end else begin
            s_d.oe_n = 1'b0;
            if (rise) begin
                s_d.sin = sin_n;
                s_d.cnt = s_q.cnt + 6'h01;
                if (s_q.cnt == SPI_HDR_LAST) begin
                    // Header done: keep opcode and address
                    s_d.op = sin_n[23:16];
                    s_d.addr = sin_n[14:0];
                    s_d.req.addr = sin_n[14:0];
                    s_d.req.rd = (sin_n[23:16] == SPI_OP_RD);
                end
                if (s_q.cnt == SPI_FRM_LAST) begin
                    // Last bit: a write goes out, counter wraps for the next frame
                    s_d.cnt = '0;
                    s_d.req.addr = s_q.addr;
                    s_d.req.data = sin_n[7:0];
                    s_d.req.wr = (s_q.op == SPI_OP_WR);
                end
            end
            if (fall && s_q.cnt == SPI_HDR_LAST + 6'h01) begin
                // First data bit goes out before the next sampling edge
                s_d.miso = rdata[7];
                s_d.sout = {rdata[6:0], 1'b0};
            end else if (fall && s_q.cnt > SPI_HDR_LAST + 6'h01) begin
                s_d.miso = s_q.sout[7];
                s_d.sout = {s_q.sout[6:0], 1'b0};
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign req = s_q.req;
    assign miso = s_q.miso;
    assign miso_oe_n = s_q.oe_n;

    property p_spi_release;
        @(posedge ref_clk) disable iff (!rst_n) ss_n |=> miso_oe_n;
    endproperty
    a_spi_release: assert property (p_spi_release) else $error("serial out driven while deselected");

    property p_spi_quiet;
        @(posedge ref_clk) disable iff (!rst_n) (ss_n [*2]) |=> !req.wr && !req.rd;
    endproperty
    a_spi_quiet: assert property (p_spi_quiet) else $error("request while deselected");

    c_spi_write: cover property (@(posedge ref_clk) disable iff (!rst_n) req.wr);
endmodule
`default_nettype wire

/* File: hsp_host_model.sv */
// Host model: drives the parallel pins or the serial link of the port.
// Assumes ref_clk runs freely and the testbench calls the tasks.
`timescale 1ns/10ps
`default_nettype none
module hsp_host_model import hsp_pkg::*; (
    input wire logic ref_clk,        // Core clock
    input wire logic [7:0] data_out, // Device data drive
    input wire logic data_oe_n,      // Device drives data when low
    input wire logic miso_out,       // Device serial out
    input wire logic miso_oe_n,      // Device drives serial out when low
    output var hsp_bus_type bus,     // Pin levels seen by the device
    output logic spi_en              // Serial-select strap
);
    logic cs_n = 1'b1; // Chip select
    logic wr_n = 1'b1; // Write strobe
    logic rd_n = 1'b1; // Read strobe
    logic [14:0] adr = '0; // Address
    logic [7:0] dq = '0; // Write data
    logic drv = 1'b0; // Host drives data
    logic sen = 1'b0; // Strap level
    logic sclk = 1'b0; // Serial clock, idle low
    logic ss_n = 1'b1; // Slave select
    logic mosi = 1'b0; // Host serial data
    logic flt = 1'b0; // Moving pattern for released lines

    assign spi_en = sen;
    // A released line must not look stable, so it toggles
    always_ff @(posedge ref_clk) begin
        flt <= ~flt;
    end
    // Resolve the shared data and serial-out lines
    always_comb begin
        bus.cs_n = cs_n;
        bus.wr_n = wr_n;
        bus.rd_n = rd_n;
        bus.addr = sen ? {sclk, ss_n, mosi, 12'h000} : adr;
        bus.data = !data_oe_n ? data_out : (drv ? dq : {8{flt}} ^ 8'h5a);
        if (sen) begin
            bus.addr[11] = miso_oe_n ? flt : miso_out;
        end
    end
    // Strap change, then settle
    task automatic set_spi(input logic v);
        @(negedge ref_clk);
        sen = v;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic par_wr(input logic [14:0] a, input logic [7:0] d, input logic both,
                          output logic clash);
        @(negedge ref_clk);
        cs_n = 1'b0;
        wr_n = 1'b0;
        rd_n = ~both;
        adr = a;
        dq = d;
        drv = 1'b1;
        clash = 1'b0;
        repeat (2) begin
            @(negedge ref_clk);
            clash |= (data_oe_n !== 1'b1);
        end
        wr_n = 1'b1;
        rd_n = 1'b1;
        @(negedge ref_clk);
        cs_n = 1'b1;
        drv = 1'b0;
    endtask
    // Read held until the device answers, bounded
    task automatic par_rd(input logic [14:0] a, output logic [7:0] q, output logic ok);
        int n;
        @(negedge ref_clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        adr = a;
        for (n = 0; n < 6 && data_oe_n !== 1'b0; n++) @(negedge ref_clk);
        ok = (data_oe_n === 1'b0);
        q = bus.data;
        rd_n = 1'b1;
        cs_n = 1'b1;
        for (n = 0; n < 6 && data_oe_n !== 1'b1; n++) @(negedge ref_clk);
        ok = ok & (data_oe_n === 1'b1);
    endtask
    task automatic spi_frame(input logic [31:0] f, output logic [7:0] q, output logic bad);
        int i;
        @(negedge ref_clk);
        ss_n = 1'b0;
        bad = 1'b0;
        for (i = 31; i >= 0; i--) begin
            mosi = f[i];
            repeat (4) @(negedge ref_clk);
            q = {q[6:0], bus.addr[11]};
            bad |= (miso_oe_n !== 1'b0);
            sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        ss_n = 1'b1;
    endtask
    // Clocks with select high must be ignored
    task automatic spi_noise(output logic bad);
        bad = 1'b0;
        repeat (16) begin
            @(negedge ref_clk);
            sclk = ~sclk;
            mosi = ~mosi;
            repeat (3) @(negedge ref_clk);
            bad |= (miso_oe_n !== 1'b1);
        end
    endtask
endmodule
`default_nettype wire

/* File: host_bus_and_serial_port_tb_top.sv */
// Self-checking bench for the host access port, random data, fixed seed.
// Assumes hsp_host_model stands in for the microcontroller.
`timescale 1ns/10ps
`default_nettype none
module host_bus_and_serial_port_tb_top import hsp_pkg::*; ;
    logic ref_clk = 1'b0; // Core clock
    logic rst_n = 1'b0; // Reset, active low
    hsp_bus_type bus; // Resolved pins
    logic spi_en; // Strap
    logic [15:0] sock_evt = '0; // Socket event pulses
    logic [3:0] com_evt = '0; // Common event pulses
    logic [63:0] rx_size = '0; // Received sizes
    logic [7:0] data_out; // Device data
    logic data_oe_n; // Data enable
    logic miso_out; // Serial out
    logic miso_oe_n; // Serial enable
    logic int_n; // Interrupt
    int fails = 0; // Mismatches
    int samples_checked = 0; // Comparisons
    int seed = 32'h33207073; // Fixed seed
    logic [14:0] madr [0:7]; // Buffer addresses
    logic [7:0] mexp [0:7]; // Expected bytes

    hsp_host_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_en(spi_en), .bus(bus),
        .sock_evt(sock_evt), .com_evt(com_evt), .rx_size(rx_size), .data_out(data_out),
        .data_oe_n(data_oe_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .int_n(int_n));
    hsp_host_model u_host (.ref_clk(ref_clk), .data_out(data_out), .data_oe_n(data_oe_n),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .bus(bus), .spi_en(spi_en));

    // Socket register address
    function automatic logic [14:0] sreg(input logic [1:0] n, input logic [7:0] off);
        return {SOCK_REGION, n, off};
    endfunction
    // Expected size byte, high byte at the lower address
    function automatic logic [7:0] rsz(input logic [1:0] n, input logic hi);
        logic [15:0] v;
        v = rx_size[n*16 +: 16];
        return hi ? v[15:8] : v[7:0];
    endfunction
    // Compare and count
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bounded read; no answer ends the run
    task automatic rd(input logic [14:0] a, output logic [7:0] q);
        logic ok;
        u_host.par_rd(a, q, ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED read handshake expected 1 seen %b", ok);
            wrap_up();
        end
    endtask
    // Write; the device must not drive meanwhile
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic clash;
        u_host.par_wr(a, d, 1'b0, clash);
        chk("drive during write", 16'h0, {15'h0, clash});
    endtask
    // Bounded wait for the interrupt level
    task automatic wait_int(input logic v);
        int n;
        for (n = 0; n < 8 && int_n !== v; n++) @(negedge ref_clk);
        if (int_n !== v) begin
            fails++;
            $display("CHECK FAILED int_n expected %b seen %b", v, int_n);
            wrap_up();
        end
    endtask

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        $display("CHECK FAILED run length expected end seen hang");
        wrap_up();
    end
    initial begin
        logic [7:0] q;
        logic b;
        int i;
        int k;
        rx_size = {$random(seed), $random(seed)};
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk("int_n", 16'h1, {15'h0, int_n});
        chk("data_oe_n", 16'h1, {15'h0, data_oe_n});
        chk("miso_oe_n", 16'h1, {15'h0, miso_oe_n});
        rd(MODE_ADDR, q);
        chk("mode reset", {8'h0, MODE_RST}, {8'h0, q});
        rd(IMR_ADDR, q);
        chk("mask reset", {8'h0, IMR_RST}, {8'h0, q});
        $display("test reset done");
        // Buffer bytes from 0x4000 up to the top byte 0x7fff, back to back
        for (i = 0; i < 8; i++) begin
            madr[i] = {1'b1, 3'(i), (i == 0) ? 11'h000 : (i == 7) ? 11'h7ff : 11'($random(seed))};
            mexp[i] = 8'($random(seed));
            wr(madr[i], mexp[i]);
        end
        u_host.par_wr(madr[0], ~mexp[0], 1'b1, b);
        chk("drive with both strobes", 16'h0, {15'h0, b});
        for (i = 0; i < 8; i++) begin
            rd(madr[i], q);
            chk("buffer byte", {8'h0, mexp[i]}, {8'h0, q});
        end
        $display("test buffer done");
        // Size bytes under both settings of the byte order bit
        for (k = 0; k < 2; k++) begin
            wr(MODE_ADDR, 8'(k << BYTE_ORDER_BIT));
            rd(MODE_ADDR, q);
            chk("mode", 16'(k << BYTE_ORDER_BIT), {8'h0, q});
            for (i = 0; i < 4; i++) begin
                rd(sreg(2'(i), RSR_HI_OFF), q);
                chk("size high", {8'h0, rsz(2'(i), 1'b1)}, {8'h0, q});
                rd(sreg(2'(i), RSR_LO_OFF), q);
                chk("size low", {8'h0, rsz(2'(i), 1'b0)}, {8'h0, q});
            end
        end
        $display("test byte order done");
        // One event per common flag bit masked, then unmasked, then cleared
        for (i = 0; i < 8; i++) begin
            wr(IMR_ADDR, 8'h00);
            @(negedge ref_clk);
            if (i < 4) sock_evt[i * 5] = 1'b1;
            else com_evt[i - 4] = 1'b1;
            @(negedge ref_clk);
            sock_evt = '0;
            com_evt = '0;
            repeat (4) begin
                @(negedge ref_clk);
                chk("masked int_n", 16'h1, {15'h0, int_n});
            end
            rd(CIR_ADDR, q);
            chk("common flags", 16'h1 << i, {8'h0, q});
            if (i < 4) begin
                rd(sreg(2'(i), SIR_OFF), q);
                chk("socket flags", 16'h1 << i, {8'h0, q});
            end
            wr(IMR_ADDR, 8'h01 << i);
            wait_int(1'b0);
            if (i == 1 || i == 3) wr(sreg(2'(i), SIR_OFF), 8'h01 << i);
            else wr(CIR_ADDR, 8'h01 << i);
            wait_int(1'b1);
            rd(CIR_ADDR, q);
            chk("flags cleared", 16'h0, {8'h0, q});
        end
        $display("test interrupt done");
        // Serial mode: parallel port off, frames carry the accesses
        u_host.set_spi(1'b1);
        u_host.par_rd(madr[1], q, b);
        chk("parallel read in serial mode", 16'h0, {15'h0, b});
        u_host.par_wr(madr[1], ~mexp[1], 1'b0, b);
        u_host.spi_noise(b);
        chk("serial out with select high", 16'h0, {15'h0, b});
        u_host.spi_frame({SPI_OP_WR, 1'b0, madr[2], 8'ha5}, q, b);
        chk("serial out enable", 16'h0, {15'h0, b});
        mexp[2] = 8'ha5;
        for (i = 1; i < 3; i++) begin
            u_host.spi_frame({SPI_OP_RD, 1'b0, madr[i], 8'h00}, q, b);
            chk("serial read", {8'h0, mexp[i]}, {8'h0, q});
        end
        repeat (2) @(negedge ref_clk);
        chk("serial out release", 16'h1, {15'h0, miso_oe_n});
        u_host.set_spi(1'b0);
        rd(madr[2], q);
        chk("parallel after serial", 16'h00a5, {8'h0, q});
        $display("test serial done");
        wrap_up();
    end
endmodule
`default_nettype wire
